// [rtl/sps_pkg.sv]
// Constants and state types of the synchronous serial port in SPI mode
package sps_pkg;

  // ----------------------------------------------------------------
  // Control and configuration field positions
  // ----------------------------------------------------------------
  localparam int CTL_EN_BIT   = 5;
  localparam int CTL_CKP_BIT  = 4;
  localparam int CTL_MODE_HI  = 3;
  localparam int CTL_MODE_LO  = 0;
  localparam int STAT_SMP_BIT = 7;
  localparam int STAT_CKE_BIT = 6;

  // ----------------------------------------------------------------
  // Port mode codes
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_MST_DIV4  = 4'h0;
  localparam logic [3:0] MODE_MST_DIV16 = 4'h1;
  localparam logic [3:0] MODE_MST_DIV64 = 4'h2;
  localparam logic [3:0] MODE_MST_TMR2  = 4'h3;
  localparam logic [3:0] MODE_SLV_SS    = 4'h4;
  localparam logic [3:0] MODE_SLV_NOSS  = 4'h5;

  // ----------------------------------------------------------------
  // Shift and timing constants
  // ----------------------------------------------------------------
  localparam int         BYTE_BITS  = 8;
  localparam logic [3:0] BIT_LAST   = 4'h7;
  localparam logic [3:0] PH_LAST    = 4'hf;
  localparam logic [4:0] HALF_DIV4  = 5'h01;
  localparam logic [4:0] HALF_DIV16 = 5'h04;
  localparam logic [4:0] HALF_DIV64 = 5'h10;

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic {
    SPS_IDLE,
    SPS_MRUN
  } sps_state_e;

  typedef struct packed {
    sps_state_e st;
    logic [7:0] sh;
    logic [7:0] rxb;
    logic       bf;
    logic       write_collision_flag;
    logic       irqf;
    logic       irq;
    logic       wake;
    logic       busy;
    logic [3:0] cnt;
    logic       samp;
    logic       pend;
    logic [3:0] ph;
    logic [4:0] div;
    logic       sck_prev;
    logic       sck_o;
    logic       sck_oe_n;
    logic       sdo_o;
    logic       sdo_oe_n;
  } sps_port_s;

  typedef struct packed {
    logic s1;
    logic s2;
  } sps_sync_s;

endpackage

// [rtl/sps_spi_port.sv]
// SPI-mode engine of the synchronous serial port
`timescale 1ns/1ps
`default_nettype none

// Contract
// - One shift register moves each byte, most significant bit first.
// - After 8 bits, copy byte to buffer, set buffer-full and port flag.
// - Next byte may shift in before the previous byte is read.
// - Buffer write during a transfer is dropped and sets write collision.
// - Write collision stays set until software clears it.
// - Reading the buffer clears buffer-full.
// - Shift register is reachable only through the buffer.
// - Enable bit connects pins; reconfigure by disable, rewrite, enable.
// - Serial input automatic; output and clock follow direction bits.
// - Shift out on programmed edge, capture on opposite; same idle polarity.
// - Master buffer write starts an 8-bit transfer with generated clock.
// - Master with output disabled still receives and flags each byte.
// - Polarity bit sets clock idle level in master and slave.
// - Master bit clock is Fosc/4, Fosc/16, Fosc/64 or timer-2/2.
// - With edge select 1, output data is valid before first edge.
// - Slave shifts on external clock; flag on last captured bit.
// - Select-controlled slave: select low enables transfer and drives output.
// - Select high floats the output at once, even mid-byte.
// - Select high or enable cleared resets module and bit counter.
// - Master in sleep freezes the transfer and resumes after wake.
// - Slave runs in sleep; completed byte flags and wakes if enabled.
// - Device reset disables the port and aborts any transfer; while reset is held, the clock and output pins are driven low.
// - Sample phase bit picks middle or end of data output time.
// - Mode, polarity, enable in control low six; phase, edge in status top.
module sps_spi_port (
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  input  wire logic [5:0] port_control_reg_in,
  input  wire logic [7:6] port_status_reg_in,
  input  wire logic       sdo_direction_in,
  input  wire logic       sck_direction_in,
  input  wire logic       buf_wr_in,
  input  wire logic [7:0] buf_wdata_in,
  input  wire logic       buf_rd_in,
  input  wire logic       write_collision_flag_clear_in,
  input  wire logic       irq_flag_clear_in,
  input  wire logic       irq_enable_in,
  input  wire logic       sleep_in,
  input  wire logic       timer2_tick_in,
  input  wire logic       spi_sck_in,
  input  wire logic       serial_in_pin_in,
  input  wire logic       slave_select_n_in,
  output logic [7:0]      buf_rdata_out,
  output logic            rx_buffer_full_out,
  output logic            write_collision_flag_out,
  output logic            serial_port_irq_flag_out,
  output logic            irq_req_out,
  output logic            wake_out,
  output logic            busy_out,
  output logic            spi_sck_out,
  output logic            spi_sck_oe_n_out,
  output logic            serial_out_pin_out,
  output logic            serial_out_pin_oe_n_out
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic sck_s;
  logic sdi_s;
  logic ss_n_s;

  sps_sync2 u_sync_sck (
    .mclk_in  (mclk_in),
    .rst_in   (rst_in),
    .async_in (spi_sck_in),
    .sync_out (sck_s)
  );

  sps_sync2 u_sync_sdi (
    .mclk_in  (mclk_in),
    .rst_in   (rst_in),
    .async_in (serial_in_pin_in),
    .sync_out (sdi_s)
  );

  sps_sync2 u_sync_ss (
    .mclk_in  (mclk_in),
    .rst_in   (rst_in),
    .async_in (slave_select_n_in),
    .sync_out (ss_n_s)
  );

  // ----------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------
  logic       en;
  logic       cpol;
  logic       cke;
  logic       input_sample_phase;
  logic [3:0] mode;
  logic       master;
  logic       slave;
  logic       ss_mode;

  assign en      = port_control_reg_in[sps_pkg::CTL_EN_BIT];
  assign cpol    = port_control_reg_in[sps_pkg::CTL_CKP_BIT];
  assign mode    = port_control_reg_in[sps_pkg::CTL_MODE_HI:sps_pkg::CTL_MODE_LO];
  assign input_sample_phase     = port_status_reg_in[sps_pkg::STAT_SMP_BIT];
  assign cke     = port_status_reg_in[sps_pkg::STAT_CKE_BIT];
  assign master  = (mode <= sps_pkg::MODE_MST_TMR2);
  assign slave   = (mode == sps_pkg::MODE_SLV_SS) || (mode == sps_pkg::MODE_SLV_NOSS);
  assign ss_mode = (mode == sps_pkg::MODE_SLV_SS);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  sps_pkg::sps_port_s q;
  sps_pkg::sps_port_s d;
  logic               cap;
  logic               shf;
  logic               tick;
  logic               done;
  logic               lead;
  logic               trail;
  logic [4:0]         half;

  always_comb begin
    d     = q;
    cap   = 1'b0;
    shf   = 1'b0;
    tick  = 1'b0;
    done  = 1'b0;
    lead  = 1'b0;
    trail = 1'b0;
    half  = sps_pkg::HALF_DIV4;
    d.sck_prev = sck_s;

    // Software clears, overridden below by hardware sets
    if (buf_rd_in) begin
      d.bf = 1'b0;
    end
    if (write_collision_flag_clear_in) begin
      d.write_collision_flag = 1'b0;
    end
    if (irq_flag_clear_in) begin
      d.irqf = 1'b0;
    end

    case (mode)
      sps_pkg::MODE_MST_DIV16: half = sps_pkg::HALF_DIV16;
      sps_pkg::MODE_MST_DIV64: half = sps_pkg::HALF_DIV64;
      default:                 half = sps_pkg::HALF_DIV4;
    endcase

    if (!en || (ss_mode && ss_n_s)) begin
      d.st   = sps_pkg::SPS_IDLE;
      d.cnt  = '0;
      d.pend = 1'b0;
      d.ph   = '0;
      d.div  = '0;
      if (en && buf_wr_in) begin
        d.sh = buf_wdata_in;
      end
    end else if (master) begin
      if ((q.st == sps_pkg::SPS_MRUN) && !sleep_in) begin
        if (mode == sps_pkg::MODE_MST_TMR2) begin
          tick = timer2_tick_in;
        end else begin
          tick  = (q.div == half - 5'h01);
          d.div = tick ? 5'h00 : q.div + 5'h01;
        end
        if (tick) begin
          shf  = q.ph[0];
          cap  = input_sample_phase ? q.ph[0] : !q.ph[0];
          d.ph = q.ph + 4'h1;
          if (q.ph == sps_pkg::PH_LAST) begin
            d.st = sps_pkg::SPS_IDLE;
          end
        end
      end
      if (buf_wr_in) begin
        if (q.st == sps_pkg::SPS_MRUN) begin
          d.write_collision_flag = 1'b1;
        end else begin
          d.sh   = buf_wdata_in;
          d.st   = sps_pkg::SPS_MRUN;
          d.ph   = '0;
          d.div  = '0;
          d.cnt  = '0;
          d.pend = 1'b0;
        end
      end
    end else if (slave) begin
      lead  = (sck_s != q.sck_prev) && (sck_s != cpol);
      trail = (sck_s != q.sck_prev) && (sck_s == cpol);
      cap   = cke ? lead : trail;
      shf   = cke ? trail : lead;
      if (buf_wr_in) begin
        if ((q.cnt != 4'h0) || q.pend || cap) begin
          d.write_collision_flag = 1'b1;
        end else begin
          d.sh = buf_wdata_in;
        end
      end
    end

    // Common capture and shift path
    if (cap) begin
      if (q.cnt == sps_pkg::BIT_LAST) begin
        done   = 1'b1;
        d.rxb  = {q.sh[6:0], sdi_s};
        d.bf   = 1'b1;
        d.irqf = 1'b1;
        d.cnt  = '0;
        if (shf || slave) begin
          d.sh   = {q.sh[6:0], sdi_s};
          d.pend = 1'b0;
        end else begin
          d.samp = sdi_s;
          d.pend = 1'b1;
        end
      end else if (shf) begin
        d.sh  = {q.sh[6:0], sdi_s};
        d.cnt = q.cnt + 4'h1;
      end else begin
        d.samp = sdi_s;
        d.pend = 1'b1;
        d.cnt  = q.cnt + 4'h1;
      end
    end else if (shf && q.pend) begin
      d.sh   = {q.sh[6:0], q.samp};
      d.pend = 1'b0;
    end

    // Pin drive
    d.sdo_o    = d.sh[7];
    d.sdo_oe_n = !(en && !sdo_direction_in && (!ss_mode || !ss_n_s));
    d.sck_oe_n = !(en && master && !sck_direction_in);
    if (master && (d.st == sps_pkg::SPS_MRUN)) begin
      d.sck_o = cpol ^ (cke ? d.ph[0] : !d.ph[0]);
    end else begin
      d.sck_o = cpol;
    end

    d.busy = (d.st == sps_pkg::SPS_MRUN) || (d.cnt != 4'h0) || d.pend;
    d.irq  = d.irqf && irq_enable_in;
    d.wake = d.irq && sleep_in;
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign buf_rdata_out            = q.rxb;
  assign rx_buffer_full_out       = q.bf;
  assign write_collision_flag_out = q.write_collision_flag;
  assign serial_port_irq_flag_out = q.irqf;
  assign irq_req_out              = q.irq;
  assign wake_out                 = q.wake;
  assign busy_out                 = q.busy;
  assign spi_sck_out              = q.sck_o;
  assign spi_sck_oe_n_out         = q.sck_oe_n;
  assign serial_out_pin_out       = q.sdo_o;
  assign serial_out_pin_oe_n_out  = q.sdo_oe_n;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  AST_WRITE_COLLISION_FLAG_STICKY: assert property (q.write_collision_flag && !write_collision_flag_clear_in |=> q.write_collision_flag)
    else $error("write collision flag dropped without a clear");

  AST_WRITE_COLLISION_FLAG_SET: assert property (
    en && master && (q.st == sps_pkg::SPS_MRUN) && buf_wr_in && !(ss_mode && ss_n_s)
    |=> q.write_collision_flag && $stable(q.sh))
    else $error("write during transfer was not refused");

  AST_BF_CLEAR: assert property (buf_rd_in && !done |=> !q.bf)
    else $error("buffer read did not clear buffer full");

  AST_DONE_LOAD: assert property (
    done |=> q.bf && q.irqf && (q.rxb == {$past(q.sh[6:0]), $past(sdi_s)}))
    else $error("completed byte not loaded with flags");

  AST_START: assert property (
    (q.st == sps_pkg::SPS_IDLE) ##1 (q.st == sps_pkg::SPS_MRUN)
    |-> q.sh == $past(buf_wdata_in))
    else $error("master transfer did not start from written byte");

  AST_SS_FLOAT: assert property (ss_mode && ss_n_s |=> q.sdo_oe_n)
    else $error("output still driven with select high");

  AST_SS_RESET: assert property (ss_mode && ss_n_s |=> (q.cnt == 4'h0) && !q.pend)
    else $error("select high did not reset the bit counter");

  AST_SLEEP_FREEZE: assert property (
    en && master && sleep_in && !buf_wr_in && (q.st == sps_pkg::SPS_MRUN)
    |=> $stable(q.ph) && $stable(q.sh) && $stable(q.sck_o))
    else $error("master transfer moved during sleep");

  AST_MSB_OUT: assert property (q.sdo_o == q.sh[7])
    else $error("serial output is not the shift register top bit");

  AST_IRQ_STICKY: assert property (q.irqf && !irq_flag_clear_in |=> q.irqf)
    else $error("port flag dropped without a clear");

  AST_IRQ_GATE: assert property (!irq_enable_in |=> !q.irq)
    else $error("interrupt request raised while disabled");

  AST_WAKE_SLEEP: assert property (!sleep_in |=> !q.wake)
    else $error("wake raised outside sleep");

  AST_DIS_RESET: assert property (
    !en |=> (q.cnt == 4'h0) && !q.pend && (q.st == sps_pkg::SPS_IDLE))
    else $error("cleared enable did not reset the port");

  AST_SCK_IDLE: assert property (
    (q.st == sps_pkg::SPS_IDLE) && !buf_wr_in |=> q.sck_o == $past(cpol))
    else $error("serial clock not at its idle level");

  AST_SCK_FLOAT: assert property (!master |=> q.sck_oe_n)
    else $error("clock pin driven outside master mode");

  AST_SDO_FLOAT: assert property (sdo_direction_in |=> q.sdo_oe_n)
    else $error("output pin driven against its direction bit");

  AST_SS_DRIVE: assert property (
    en && ss_mode && !ss_n_s && !sdo_direction_in |=> !q.sdo_oe_n)
    else $error("selected slave does not drive its output");

  AST_MST_GO: assert property (
    en && master && (q.st == sps_pkg::SPS_IDLE) && buf_wr_in |=> q.st == sps_pkg::SPS_MRUN)
    else $error("master write in idle did not start a transfer");

  AST_RST_IDLE: assert property (
    @(posedge mclk_in) disable iff (1'b0) rst_in |=> (q.st == sps_pkg::SPS_IDLE) && !q.busy)
    else $error("reset did not abort the transfer");

  AST_SET_WINS: assert property (done && buf_rd_in |=> q.bf)
    else $error("buffer read beat a completed byte");

  AST_CNT_RANGE: assert property (q.cnt <= sps_pkg::BIT_LAST)
    else $error("bit counter beyond the last bit");

endmodule

`default_nettype wire

// [rtl/sps_sync2.sv]
// Two flip-flop synchroniser for one asynchronous pin
`timescale 1ns/1ps
`default_nettype none

module sps_sync2 (
  input  wire logic mclk_in,
  input  wire logic rst_in,
  input  wire logic async_in,
  output logic      sync_out
);

  sps_pkg::sps_sync_s q;
  sps_pkg::sps_sync_s d;

  always_comb begin
    d    = q;
    d.s1 = async_in;
    d.s2 = q.s1;
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.s2;

endmodule

`default_nettype wire

// [tb/sps_far_end.sv]
// Far-end SPI peer model: slave to the port's clock or master of it
`timescale 1ns/1ps
`default_nettype none

module sps_far_end (
  input  wire logic mclk_in,
  input  wire logic sck_in,
  input  wire logic sdo_in,
  output logic      sck_out,
  output logic      to_dev_out,
  output logic      ss_n_out,
  output logic [7:0] rx_out
);
  logic [7:0] sh;
  logic       own;
  wire        clk_w = own ? sck_out : sck_in;

  initial begin
    own = 1'b0;
    sck_out = 1'b0;
    ss_n_out = 1'b1;
    sh = 8'h00;
    rx_out = 8'h00;
    to_dev_out = 1'b0;
  end

  task automatic load(input logic [7:0] b);
    sh = b;
    to_dev_out = b[7];
  endtask

  // Capture on leading edge, shift on trailing edge
  always @(posedge clk_w) rx_out <= {rx_out[6:0], sdo_in};
  always @(negedge clk_w) begin
    sh = {sh[6:0], ~sh[0]};
    to_dev_out = sh[7];
  end

  // Master role: clock idles low outside the frame
  task automatic run(input int nbits);
    @(negedge mclk_in);
    own = 1'b1;
    ss_n_out = 1'b0;
    repeat (8) @(negedge mclk_in);
    repeat (nbits) begin
      sck_out = 1'b1;
      repeat (8) @(negedge mclk_in);
      sck_out = 1'b0;
      repeat (8) @(negedge mclk_in);
    end
    ss_n_out = 1'b1;
    repeat (8) @(negedge mclk_in);
    own = 1'b0;
  endtask
endmodule

`default_nettype wire

// [tb/sps_spi_port_tb_top.sv]
// Self-checking bench for the SPI-mode serial port
`timescale 1ns/1ps
`default_nettype none

module sps_spi_port_tb_top;
  logic        mclk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [5:0]  ctl = 6'h00;
  logic [7:6]  stat = 2'h0;
  logic        sdo_dir = 1'b1;
  logic        sck_dir = 1'b1;
  logic        wr = 1'b0;
  logic [7:0]  wdata = 8'h00;
  logic [2:0]  sw = 3'h0;
  logic        ien = 1'b0;
  logic        slp = 1'b0;
  logic        tick = 1'b0;
  logic [7:0]  rdata;
  logic [7:0]  far_rx;
  logic        bf, write_collision_flag, irqf, irq, wake, busy, sck, sck_oe_n, serial_out_pin, sdo_oe_n;
  logic        far_sck, far_d, far_ss_n;
  int          fail_count = 0;
  int          n_checks = 0;
  int          busy_cycles = 0;
  wire         sck_line = sck_oe_n ? far_sck : sck;
  wire         sdo_line = sdo_oe_n ? ~serial_out_pin : serial_out_pin;

  initial forever #50 mclk_in = ~mclk_in;
  always @(negedge mclk_in) tick <= ~tick;
  always @(negedge mclk_in) if (busy === 1'b1) busy_cycles = busy_cycles + 1;

  sps_spi_port sps_spi_port_inst (
    .mclk_in(mclk_in), .rst_in(rst_in), .port_control_reg_in(ctl),
    .port_status_reg_in(stat), .sdo_direction_in(sdo_dir), .sck_direction_in(sck_dir),
    .buf_wr_in(wr), .buf_wdata_in(wdata), .buf_rd_in(sw[0]), .write_collision_flag_clear_in(sw[1]),
    .irq_flag_clear_in(sw[2]), .irq_enable_in(ien), .sleep_in(slp),
    .timer2_tick_in(tick), .spi_sck_in(sck_line), .serial_in_pin_in(far_d),
    .slave_select_n_in(far_ss_n), .buf_rdata_out(rdata), .rx_buffer_full_out(bf),
    .write_collision_flag_out(write_collision_flag), .serial_port_irq_flag_out(irqf),
    .irq_req_out(irq), .wake_out(wake), .busy_out(busy), .spi_sck_out(sck),
    .spi_sck_oe_n_out(sck_oe_n), .serial_out_pin_out(serial_out_pin),
    .serial_out_pin_oe_n_out(sdo_oe_n));

  sps_far_end sps_far_end_inst (
    .mclk_in(mclk_in), .sck_in(sck_line), .sdo_in(sdo_line), .sck_out(far_sck),
    .to_dev_out(far_d), .ss_n_out(far_ss_n), .rx_out(far_rx));

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic bwrite(input logic [7:0] b);
    @(negedge mclk_in);
    wr = 1'b1;
    wdata = b;
    @(negedge mclk_in);
    wr = 1'b0;
  endtask

  task automatic strobe(input logic [2:0] m);
    @(negedge mclk_in);
    sw = m;
    @(negedge mclk_in);
    sw = 3'h0;
    @(negedge mclk_in);
  endtask

  task automatic wait_idle;
    int k;
    k = 0;
    repeat (2) @(negedge mclk_in);
    while (busy !== 1'b0 && k < 5000) begin
      @(negedge mclk_in);
      k++;
    end
    repeat (2) @(negedge mclk_in);
  endtask

  task automatic set_ctl(input logic [5:0] c);
    @(negedge mclk_in);
    ctl = {1'b0, c[4:0]};
    @(negedge mclk_in);
    ctl = c;
    repeat (3) @(negedge mclk_in);
  endtask

  task automatic summarize;
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge mclk_in);
    fail_count++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    int m;
    repeat (2) @(negedge mclk_in);
    rst_in = 1'b0;
    repeat (3) @(negedge mclk_in);
    check({bf, write_collision_flag, irqf, busy}, 16'h0);
    check(sdo_oe_n, 1'b1);
    $display("test reset done");

    stat = 2'b01;
    sck_dir = 1'b0;
    sdo_dir = 1'b0;
    ien = 1'b1;
    set_ctl({2'b10, sps_pkg::MODE_MST_DIV64});
    sps_far_end_inst.load(8'h3c);
    busy_cycles = 0;
    bwrite(8'ha5);
    bwrite(8'h11);
    check(write_collision_flag, 1'b1);
    wait_idle();
    check(busy_cycles, 16'd256);
    check(rdata, 8'h3c);
    check(far_rx, 8'ha5);
    check({bf, irqf, irq}, 16'h7);
    check(write_collision_flag, 1'b1);
    strobe(3'b001);
    check(bf, 1'b0);
    check(rdata, 8'h3c);
    strobe(3'b110);
    check({write_collision_flag, irqf, irq}, 16'h0);
    $display("test master transfer done");

    sdo_dir = 1'b1;
    for (m = 0; m < 4; m++) begin
      set_ctl({2'b10, m[3:0]});
      busy_cycles = 0;
      bwrite(8'h5a);
      wait_idle();
      check(sdo_oe_n, 1'b1);
      check({bf, irqf}, 16'h3);
      if (m < 3) check(busy_cycles, 16'd16 << (2 * m));
      strobe(3'b101);
    end
    stat = 2'b11;
    sdo_dir = 1'b0;
    set_ctl({2'b10, sps_pkg::MODE_MST_DIV16});
    sps_far_end_inst.load(8'h5a);
    bwrite(8'h69);
    wait_idle();
    check(rdata, 8'h5a);
    check(far_rx, 8'h69);
    strobe(3'b101);
    busy_cycles = 0;
    bwrite(8'h33);
    repeat (10) @(negedge mclk_in);
    slp = 1'b1;
    repeat (20) @(negedge mclk_in);
    slp = 1'b0;
    wait_idle();
    check(busy_cycles, 16'd84);
    strobe(3'b101);
    set_ctl({2'b11, sps_pkg::MODE_MST_DIV4});
    check(sck, 1'b1);
    $display("test master modes done");

    sck_dir = 1'b1;
    sdo_dir = 1'b0;
    set_ctl({2'b10, sps_pkg::MODE_SLV_SS});
    bwrite(8'hc3);
    sps_far_end_inst.load(8'h96);
    sps_far_end_inst.run(3);
    check(sdo_oe_n, 1'b1);
    check(bf, 1'b0);
    bwrite(8'hc3);
    sps_far_end_inst.load(8'h96);
    slp = 1'b1;
    fork
      sps_far_end_inst.run(8);
      begin
        repeat (30) @(negedge mclk_in);
        check(sdo_oe_n, 1'b0);
      end
    join
    check(rdata, 8'h96);
    check(far_rx, 8'hc3);
    check({bf, irqf, wake}, 16'h7);
    slp = 1'b0;
    $display("test slave done");
    summarize();
  end
endmodule

`default_nettype wire
